//--- include/grcc_defs.svh
// Constants for the gain-ranging channel control block.
// Assumes a 20 MHz system clock and AXI4-Lite register access.
`ifndef GRCC_DEFS_SVH
`define GRCC_DEFS_SVH

// Timing: encode period and its quarter, in ns and in clock cycles
`define GRCC_CLK_PERIOD_NS 50
`define GRCC_ENC_PERIOD_NS 800
`define GRCC_QTR_CYC (((`GRCC_ENC_PERIOD_NS) / 4) / (`GRCC_CLK_PERIOD_NS))
`define GRCC_QCNT_LAST 8'((`GRCC_QTR_CYC) - 1)

// Register byte offsets
`define GRCC_OFS_CTRL 8'h00
`define GRCC_OFS_THRESH 8'h04
`define GRCC_OFS_STATUS 8'h08
`define GRCC_OFS_COUNT 8'h0C

// Reset values
`define GRCC_CTRL_RST 1'b0
`define GRCC_THRESH_RST 12'h040

// Field positions
`define GRCC_CTRL_RUN 0
`define GRCC_THR_LO 7
`define GRCC_THR_HI 11

// Range steps above the lowest range
`define GRCC_RANGE_STEPS 5
`define GRCC_RANGE_MIN 3'h0

// Bus responses
`define GRCC_RESP_OKAY 2'h0
`define GRCC_RESP_SLVERR 2'h2

`endif

//--- include/grcc_pkg.sv
// Types for the gain-ranging channel control block.
// Assumes grcc_defs.svh carries every numeric constant.
package grcc_pkg;

	// Encode period phases, one-hot
	typedef enum logic [4:0] {
		PH_IDLE = 5'h01,
		PH_CAL  = 5'h02,
		PH_GAP  = 5'h04,
		PH_SET1 = 5'h08,
		PH_SET2 = 5'h10
	} grcc_phase_type;

	// Step attenuator settings
	typedef enum logic [1:0] {
		ATT_0DB  = 2'h0,
		ATT_12DB = 2'h1,
		ATT_24DB = 2'h2
	} grcc_atten_type;

endpackage

//--- design/grcc_control.sv
// Gain-ranging channel control: encode sequencer, peak-driven range
// choice with hysteresis, channel steering, output buffer and registers.
// Assumes mode pins are static straps from outside the clock domain and
// that peak magnitude and ADC mantissa come from same-clock logic.
`include "grcc_defs.svh"

module grcc_control (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_b,
	// AXI4-Lite write address and data
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// AXI4-Lite write response
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Mode strap pins
	input  wire logic        modeSelA,
	input  wire logic        modeSelB,
	// Front end measurements
	input  wire logic [11:0] peakMag,
	input  wire logic [10:0] adcMantissa,
	// Analog front end controls
	output logic             thHold,
	output logic             peakInit,
	output logic             peakTrack,
	output logic             filterDischarge,
	output logic             filterAmpEn,
	output logic             inputSelB,
	output logic [1:0]       attenSelA,
	output logic [1:0]       attenSelB,
	output logic             gainHigh,
	// Output sample stream
	output logic             outValid,
	input  wire logic        outReady,
	output logic [10:0]      outMantissa,
	output logic [2:0]       outRange,
	output logic             channelTagOut
);

	////////////////////////////////////////////////////////////////////
	// Declarations

	grcc_pkg::grcc_phase_type phase_q;
	logic [7:0]  qCnt_q;
	logic        qLast;
	logic        modeA_meta_q, modeB_meta_q, modeA_q, modeB_q;
	logic        modeValid, dualMode;
	logic        run_q;
	logic [11:0] thrBase_q;
	logic        go, stall, periodEnd, startPeriod, pushReq;
	logic        evalChanB_q, convChanB_q, convValid_q;
	logic [2:0]  rangeA_q, rangeB_q, convRange_q, appliedRange_q;
	logic [11:0] peakMax_q;
	logic [2:0]  rangeUp, rangeDn, rangeCur, rangeNew;
	logic        thHold_q, peakInit_q, peakTrack_q, discharge_q, ampEn_q;
	logic        inputSelB_q, gainHigh_q;
	logic [1:0]  attenA_q, attenB_q;
	logic [14:0] pushData;
	logic        inReady, push, pop;
	logic [14:0] outData_q, skidData_q;
	logic        outValid_q, skidValid_q;
	logic [15:0] wordCnt_q;
	logic        awHeld_q, wHeld_q;
	logic [7:0]  awAddr_q;
	logic [31:0] wData_q;
	logic [3:0]  wStrb_q;
	logic        bvalid_q, rvalid_q;
	logic [1:0]  bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic        doWrite;

	////////////////////////////////////////////////////////////////////
	// Mode straps: two-flop synchroniser, then decode

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			modeA_meta_q <= 1'b0;
			modeB_meta_q <= 1'b0;
			modeA_q      <= 1'b0;
			modeB_q      <= 1'b0;
		end else begin
			modeA_meta_q <= modeSelA;
			modeB_meta_q <= modeSelB;
			modeA_q      <= modeA_meta_q;
			modeB_q      <= modeB_meta_q;
		end
	end

	// Both straps low is not a mode: the sequencer idles
	assign modeValid = modeA_q | modeB_q;
	assign dualMode  = modeA_q & modeB_q;

	////////////////////////////////////////////////////////////////////
	// Encode sequencer: four quarters per period

	assign qLast   = (qCnt_q == `GRCC_QCNT_LAST);
	assign go      = run_q & modeValid;
	assign pushReq = convValid_q;
	// A full buffer freezes the period end, so no converted word is lost
	assign stall     = pushReq & ~inReady;
	assign periodEnd = (phase_q == grcc_pkg::PH_SET2) & qLast & ~stall;
	assign startPeriod = go & ((phase_q == grcc_pkg::PH_IDLE) | periodEnd);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			phase_q <= grcc_pkg::PH_IDLE;
			qCnt_q  <= 8'h00;
		end else begin
			case (phase_q)
				grcc_pkg::PH_IDLE: begin
					qCnt_q <= 8'h00;
					if (go) begin
						phase_q <= grcc_pkg::PH_CAL;
					end
				end
				grcc_pkg::PH_CAL: begin
					qCnt_q <= qLast ? 8'h00 : qCnt_q + 8'h01;
					if (qLast) begin
						phase_q <= grcc_pkg::PH_GAP;
					end
				end
				grcc_pkg::PH_GAP: begin
					qCnt_q <= qLast ? 8'h00 : qCnt_q + 8'h01;
					if (qLast) begin
						phase_q <= grcc_pkg::PH_SET1;
					end
				end
				grcc_pkg::PH_SET1: begin
					qCnt_q <= qLast ? 8'h00 : qCnt_q + 8'h01;
					if (qLast) begin
						phase_q <= grcc_pkg::PH_SET2;
					end
				end
				grcc_pkg::PH_SET2: begin
					if (!qLast) begin
						qCnt_q <= qCnt_q + 8'h01;
					end else if (!stall) begin
						qCnt_q  <= 8'h00;
						phase_q <= go ? grcc_pkg::PH_CAL : grcc_pkg::PH_IDLE;
					end
				end
				default: begin
					phase_q <= grcc_pkg::PH_IDLE;
					qCnt_q  <= 8'h00;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Encode edge actions and filter amplifier control

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			thHold_q    <= 1'b0;
			peakInit_q  <= 1'b0;
			peakTrack_q <= 1'b0;
			discharge_q <= 1'b0;
			ampEn_q     <= 1'b0;
		end else begin
			// Hold and detector reset pulse together, on the same edge
			thHold_q    <= startPeriod;
			peakInit_q  <= startPeriod;
			peakTrack_q <= startPeriod |
				((phase_q == grcc_pkg::PH_CAL) & ~qLast);
			// Filter is shared, so discharging it cuts channel feedthrough
			discharge_q <= startPeriod |
				((phase_q == grcc_pkg::PH_CAL) & ~qLast);
			ampEn_q <= ((phase_q == grcc_pkg::PH_GAP) & qLast) |
				(phase_q == grcc_pkg::PH_SET1) |
				((phase_q == grcc_pkg::PH_SET2) & ~periodEnd);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Channel sequencing

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			evalChanB_q <= 1'b0;
			convChanB_q <= 1'b0;
			convRange_q <= `GRCC_RANGE_MIN;
			convValid_q <= 1'b0;
		end else begin
			if (startPeriod) begin
				// The sample prepared last period is the one now held
				convChanB_q <= inputSelB_q;
				convRange_q <= appliedRange_q;
				convValid_q <= (phase_q != grcc_pkg::PH_IDLE);
				if (dualMode) begin
					evalChanB_q <= ~inputSelB_q;
				end else begin
					evalChanB_q <= ~modeA_q;
				end
			end else if (periodEnd) begin
				convValid_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Peak detector and range decision

	// Thresholds double per step, so each step spans 6 dB
	function automatic logic [2:0] rangeOf(
		input logic [12:0] mag,
		input logic [11:0] base
	);
		logic [2:0]  n;
		logic [16:0] thr;
		n   = `GRCC_RANGE_MIN;
		thr = {5'h00, base};
		for (int k = 0; k < `GRCC_RANGE_STEPS; k++) begin
			if ({4'h0, mag} >= thr) begin
				n = n + 3'h1;
			end
			thr = {thr[15:0], 1'b0};
		end
		return n;
	endfunction

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			peakMax_q <= 12'h000;
		end else if (startPeriod) begin
			peakMax_q <= 12'h000;
		end else if (peakTrack_q && peakMag > peakMax_q) begin
			peakMax_q <= peakMag;
		end
	end

	assign rangeUp  = rangeOf({1'b0, peakMax_q}, thrBase_q);
	// Doubling the peak moves every threshold down by 6 dB
	assign rangeDn  = rangeOf({peakMax_q, 1'b0}, thrBase_q);
	assign rangeCur = evalChanB_q ? rangeB_q : rangeA_q;

	always_comb begin
		if (rangeUp > rangeCur) begin
			rangeNew = rangeUp;
		end else if (rangeDn < rangeCur) begin
			rangeNew = rangeDn;
		end else begin
			rangeNew = rangeCur;
		end
	end

	// Decision at the close of calibration, one period before conversion
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rangeA_q       <= `GRCC_RANGE_MIN;
			rangeB_q       <= `GRCC_RANGE_MIN;
			appliedRange_q <= `GRCC_RANGE_MIN;
			inputSelB_q    <= 1'b0;
		end else if (phase_q == grcc_pkg::PH_CAL && qLast) begin
			appliedRange_q <= rangeNew;
			inputSelB_q    <= evalChanB_q;
			if (evalChanB_q) begin
				rangeB_q <= rangeNew;
			end else begin
				rangeA_q <= rangeNew;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Attenuator and gain settings, applied ahead of the settle quarters

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			attenA_q   <= grcc_pkg::ATT_0DB;
			attenB_q   <= grcc_pkg::ATT_0DB;
			gainHigh_q <= 1'b1;
		end else if (phase_q == grcc_pkg::PH_CAL && qLast) begin
			// Code bits 2:1 pick the attenuator, bit 0 low sets gainHigh for 6 dB more gain
			gainHigh_q <= ~rangeNew[0];
			if (evalChanB_q) begin
				attenB_q <= rangeNew[2:1];
			end else begin
				attenA_q <= rangeNew[2:1];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Two-entry output buffer: output register plus skid register

	// Tag is high for channel A words
	assign pushData = {adcMantissa, convRange_q, ~convChanB_q};
	assign inReady  = ~skidValid_q;
	assign push     = pushReq & inReady & (phase_q == grcc_pkg::PH_SET2) &
		qLast;
	assign pop      = outValid_q & outReady;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			outData_q   <= 15'h0000;
			skidData_q  <= 15'h0000;
			outValid_q  <= 1'b0;
			skidValid_q <= 1'b0;
		end else if (!outValid_q || pop) begin
			if (skidValid_q) begin
				outData_q   <= skidData_q;
				outValid_q  <= 1'b1;
				skidValid_q <= push;
				if (push) begin
					skidData_q <= pushData;
				end
			end else begin
				outValid_q <= push;
				if (push) begin
					outData_q <= pushData;
				end
			end
		end else if (push) begin
			skidData_q  <= pushData;
			skidValid_q <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wordCnt_q <= 16'h0000;
		end else if (push) begin
			wordCnt_q <= wordCnt_q + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave: write path

	assign awready = ~awHeld_q & ~bvalid_q;
	assign wready  = ~wHeld_q & ~bvalid_q;
	assign doWrite = awHeld_q & wHeld_q & ~bvalid_q;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			awHeld_q <= 1'b0;
			wHeld_q  <= 1'b0;
			awAddr_q <= 8'h00;
			wData_q  <= 32'h0000_0000;
			wStrb_q  <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q  <= `GRCC_RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				awHeld_q <= 1'b1;
				awAddr_q <= awaddr;
			end
			if (wvalid && wready) begin
				wHeld_q <= 1'b1;
				wData_q <= wdata;
				wStrb_q <= wstrb;
			end
			if (doWrite) begin
				awHeld_q <= 1'b0;
				wHeld_q  <= 1'b0;
				bvalid_q <= 1'b1;
				if (awAddr_q == `GRCC_OFS_CTRL ||
					awAddr_q == `GRCC_OFS_THRESH) begin
					bresp_q <= `GRCC_RESP_OKAY;
				end else begin
					bresp_q <= `GRCC_RESP_SLVERR;
				end
			end else if (bvalid_q && bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Software controls: run enable and base threshold
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			run_q     <= `GRCC_CTRL_RST;
			thrBase_q <= `GRCC_THRESH_RST;
		end else if (doWrite) begin
			if (awAddr_q == `GRCC_OFS_CTRL) begin
				if (wStrb_q[0]) begin
					run_q <= wData_q[`GRCC_CTRL_RUN];
				end
			end else if (awAddr_q == `GRCC_OFS_THRESH) begin
				if (wStrb_q[0]) begin
					thrBase_q[7:0] <= wData_q[7:0];
				end
				if (wStrb_q[1]) begin
					thrBase_q[11:8] <= wData_q[11:8];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave: read path

	assign arready = ~rvalid_q;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= `GRCC_RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_q <= 1'b1;
			rresp_q  <= `GRCC_RESP_OKAY;
			if (araddr == `GRCC_OFS_CTRL) begin
				rdata_q <= {31'h0000_0000, run_q};
			end else if (araddr == `GRCC_OFS_THRESH) begin
				rdata_q <= {20'h0_0000, thrBase_q};
			end else if (araddr == `GRCC_OFS_STATUS) begin
				rdata_q <= {19'h0_0000, stall, outValid_q, convValid_q,
					evalChanB_q, rangeB_q, rangeA_q, ~modeValid,
					modeB_q, modeA_q};
			end else if (araddr == `GRCC_OFS_COUNT) begin
				rdata_q <= {16'h0000, wordCnt_q};
			end else begin
				rdata_q <= 32'h0000_0000;
				rresp_q <= `GRCC_RESP_SLVERR;
			end
		end else if (rvalid_q && rready) begin
			rvalid_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs

	assign bvalid          = bvalid_q;
	assign bresp           = bresp_q;
	assign rvalid          = rvalid_q;
	assign rdata           = rdata_q;
	assign rresp           = rresp_q;
	assign thHold          = thHold_q;
	assign peakInit        = peakInit_q;
	assign peakTrack       = peakTrack_q;
	assign filterDischarge = discharge_q;
	assign filterAmpEn     = ampEn_q;
	assign inputSelB       = inputSelB_q;
	assign attenSelA       = attenA_q;
	assign attenSelB       = attenB_q;
	assign gainHigh        = gainHigh_q;
	assign outValid        = outValid_q;
	assign outMantissa     = outData_q[14:4];
	assign outRange        = outData_q[3:1];
	assign channelTagOut   = outData_q[0];

endmodule

//--- verification/grcc_control_sva.sv
// Checker for grcc_control: encode phase timing, settings and stream hold.
// Assumes Q = 4 cycles and sees only the top module's ports.
module grcc_control_sva (
	// Clock and reset
	input wire logic        clock,
	input wire logic        rst_b,
	// Front end controls
	input wire logic        thHold,
	input wire logic        peakInit,
	input wire logic        peakTrack,
	input wire logic        filterDischarge,
	input wire logic        filterAmpEn,
	input wire logic        inputSelB,
	input wire logic [1:0]  attenSelA,
	input wire logic [1:0]  attenSelB,
	input wire logic        gainHigh,
	// Output stream
	input wire logic        outValid,
	input wire logic        outReady,
	input wire logic [10:0] outMantissa,
	input wire logic [2:0]  outRange,
	input wire logic        channelTagOut
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	////////////////////////////////////////////////////////////////////
	// Calibration quarter, then the quarter with the amplifier off
	sequence s_cal;
		peakTrack [*4] ##1 !peakTrack;
	endsequence
	sequence s_gap;
		!filterAmpEn [*4] ##1 filterAmpEn;
	endsequence

	a_hold_init_pair: assert property (thHold == peakInit)
		else $error("hold and detector init not paired");
	a_hold_starts_cal: assert property (thHold |->
		peakTrack && !filterAmpEn)
		else $error("hold pulse outside calibration start");
	a_track_quarter: assert property ($rose(peakTrack) |-> s_cal)
		else $error("calibration not one quarter long");
	a_discharge_match: assert property (filterDischarge == peakTrack)
		else $error("discharge differs from calibration");
	a_amp_gap: assert property ($fell(peakTrack) |-> s_gap)
		else $error("amplifier not re-enabled one quarter later");
	a_amp_span: assert property ($rose(filterAmpEn) |-> filterAmpEn [*8])
		else $error("settling window too short");
	a_hold_after_amp: assert property ($fell(filterAmpEn) |-> thHold)
		else $error("amplifier dropped without a hold");
	// Settings may only move at the end of calibration
	a_settle_point: assert property (
		!$stable({attenSelA, attenSelB, gainHigh, inputSelB}) |->
		$fell(peakTrack))
		else $error("settings moved outside calibration end");
	a_atten_legal: assert property (attenSelA != 2'h3 && attenSelB != 2'h3)
		else $error("attenuator code out of range");
	a_out_stall_hold: assert property (outValid && !outReady |=>
		outValid && $stable({outMantissa, outRange, channelTagOut}))
		else $error("output word changed while stalled");
	a_range_legal: assert property (outValid |-> outRange <= 3'h5)
		else $error("range code above five");
endmodule

bind grcc_control grcc_control_sva i_grcc_control_sva (
	.clock(clock), .rst_b(rst_b), .thHold(thHold), .peakInit(peakInit),
	.peakTrack(peakTrack), .filterDischarge(filterDischarge),
	.filterAmpEn(filterAmpEn), .inputSelB(inputSelB),
	.attenSelA(attenSelA), .attenSelB(attenSelB), .gainHigh(gainHigh),
	.outValid(outValid), .outReady(outReady), .outMantissa(outMantissa),
	.outRange(outRange), .channelTagOut(channelTagOut)
);

//--- verification/grcc_sink_model.sv
// Capture model standing at the output stream of grcc_control.
// Assumes the bench raises holdOff to make it stall.
module grcc_sink_model (
	// Clock and reset
	input wire logic        clock,
	input wire logic        rst_b,
	// Stall request
	input wire logic        holdOff,
	// Output stream
	input wire logic        outValid,
	output logic            outReady,
	input wire logic [10:0] outMantissa,
	input wire logic [2:0]  outRange,
	input wire logic        channelTagOut
);
	timeunit 1ns;
	timeprecision 1ps;
	// Tag, range and mantissa of every word taken
	logic [14:0] wordQ [$];

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			outReady <= 1'b0;
		end else begin
			outReady <= !holdOff;
			if (outValid && outReady) begin
				wordQ.push_back({channelTagOut, outRange, outMantissa});
			end
		end
	end
endmodule

//--- verification/test_gain_ranging_channel_control.sv
// Bench for grcc_control: range table, hysteresis, modes and stalls.
// Assumes the default threshold base and a 16-cycle encode period.
`include "grcc_defs.svh"
module test_gain_ranging_channel_control;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [11:0] peak;
		logic [2:0]  rng;
	} grcc_row_type;

	logic        clock = 1'b0;
	logic        rst_b = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic [3:0]  wstrb = 4'hF;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0, holdOff = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, rs;
	logic        modeSelA = 1'b0, modeSelB = 1'b0;
	logic [11:0] peakMag = 12'h000;
	logic [10:0] adcMantissa = 11'h000, outMantissa;
	logic        thHold, peakInit, peakTrack, filterDischarge, filterAmpEn;
	logic        inputSelB, gainHigh, outValid, outReady, channelTagOut;
	logic [1:0]  attenSelA, attenSelB;
	logic [2:0]  outRange;
	int          mismatches = 0, totalChecks = 0, cycles = 0;
	// Rising past each threshold, then falling through the hysteresis
	grcc_row_type rows [10] = '{
		'{12'h000, 3'h0}, '{12'h040, 3'h1}, '{12'h080, 3'h2},
		'{12'h100, 3'h3}, '{12'h200, 3'h4}, '{12'h400, 3'h5},
		'{12'h3E8, 3'h5}, '{12'h1F4, 3'h4}, '{12'h07F, 3'h2},
		'{12'h03F, 3'h1}};

	grcc_control i_grcc_control (.clock(clock), .rst_b(rst_b),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .modeSelA(modeSelA),
		.modeSelB(modeSelB), .peakMag(peakMag), .adcMantissa(adcMantissa),
		.thHold(thHold), .peakInit(peakInit), .peakTrack(peakTrack),
		.filterDischarge(filterDischarge), .filterAmpEn(filterAmpEn),
		.inputSelB(inputSelB), .attenSelA(attenSelA),
		.attenSelB(attenSelB), .gainHigh(gainHigh), .outValid(outValid),
		.outReady(outReady), .outMantissa(outMantissa),
		.outRange(outRange), .channelTagOut(channelTagOut));
	grcc_sink_model i_grcc_sink_model (.clock(clock), .rst_b(rst_b),
		.holdOff(holdOff), .outValid(outValid), .outReady(outReady),
		.outMantissa(outMantissa), .outRange(outRange),
		.channelTagOut(channelTagOut));

	always #25 clock = ~clock;
	// Mantissa steps once per encode period, so lost words show as gaps
	always @(posedge clock) begin
		if (thHold === 1'b1) adcMantissa <= adcMantissa + 11'h001;
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			wrapUp();
		end
	end

	////////////////////////////////////////////////////////////////////
	task automatic check_val(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		totalChecks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic check_word(input logic [14:0] got, input logic [14:0] exp);
		totalChecks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t word got %h want %h", $time, got, exp);
		end
	endtask
	task automatic do_reset();
		rst_b <= 1'b0;
		repeat (16) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
	endtask
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clock);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
		@(posedge clock);
	endtask
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clock);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge clock);
	endtask
	task automatic wrapUp();
		$display("checks %0d mismatches %0d", totalChecks, mismatches);
		if (mismatches == 0 && totalChecks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		logic [14:0] w, p;
		int base;
		do_reset();
		check_val({31'h0, thHold}, 32'h0, "idle hold");
		check_val({31'h0, gainHigh}, 32'h1, "reset gain");
		axi_read(`GRCC_OFS_CTRL, rd, rs);
		check_val(rd, 32'h0, "ctrl reset");
		axi_read(`GRCC_OFS_THRESH, rd, rs);
		check_val(rd, {20'h0, `GRCC_THRESH_RST}, "thresh reset");
		axi_read(8'h10, rd, rs);
		check_val({rd[29:0], rs}, {30'h0, `GRCC_RESP_SLVERR}, "unmapped");
		axi_write(`GRCC_OFS_STATUS, 32'h0, rs);
		check_val({30'h0, rs}, {30'h0, `GRCC_RESP_SLVERR}, "status write");
		// Both straps low: running must give no words
		axi_write(`GRCC_OFS_CTRL, 32'h1, rs);
		repeat (64) @(posedge clock);
		check_val(i_grcc_sink_model.wordQ.size(), 32'h0, "invalid");
		$display("register and invalid mode test done");
		modeSelA <= 1'b1;
		foreach (rows[i]) begin
			peakMag <= rows[i].peak;
			repeat (64) @(posedge clock);
			w = i_grcc_sink_model.wordQ[$];
			check_val({24'h0, inputSelB, gainHigh, attenSelA, w[14:11]},
				{24'h0, 1'b0, !rows[i].rng[0], rows[i].rng[2:1], 1'b1,
				rows[i].rng}, "single A");
			$display("range row %0d done", i);
		end
		do_reset();
		modeSelA <= 1'b0;
		modeSelB <= 1'b1;
		peakMag <= 12'h100;
		axi_write(`GRCC_OFS_CTRL, 32'h1, rs);
		repeat (64) @(posedge clock);
		w = i_grcc_sink_model.wordQ[$];
		check_val({22'h0, inputSelB, gainHigh, attenSelA, attenSelB,
			w[14:11]}, {22'h0, 6'b1_0_00_01, 4'h3}, "single B");
		// Status: strap B seen, strap A clear, mode valid
		axi_read(`GRCC_OFS_STATUS, rd, rs);
		check_val({29'h0, rd[2:0]}, 32'h2, "status mode");
		$display("single B test done");
		// Dual mode with a long stall in the middle
		do_reset();
		modeSelA <= 1'b1;
		axi_write(`GRCC_OFS_CTRL, 32'h1, rs);
		repeat (48) @(posedge clock);
		base = i_grcc_sink_model.wordQ.size();
		holdOff <= 1'b1;
		repeat (80) @(posedge clock);
		holdOff <= 1'b0;
		repeat (128) @(posedge clock);
		check_val(32'(i_grcc_sink_model.wordQ.size() > base + 6), 32'h1,
			"dual words");
		for (int i = base + 1; i < i_grcc_sink_model.wordQ.size(); i++) begin
			p = i_grcc_sink_model.wordQ[i - 1];
			w = i_grcc_sink_model.wordQ[i];
			// Peak stays at 12'h100, so both channels sit in range 3
			check_word(w, {!p[14], 3'h3,
				p[10:0] + 11'h001});
		end
		$display("dual stall test done");
		wrapUp();
	end
endmodule
